// ===== hdl/asri_top.v
// asri_top.v - digital control and serial readout of a 16-bit converter
// assumes the host drives strobe, serial clock and chain input asynchronously;
// samples arrive from the analog core through a fifo
`timescale 1ns/1ps
`include "asri_map.vh"
module asri_top (
  // clock and reset
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  // host link pins
  input wire CONVERT_STROBE_IN,
  input wire SERIAL_CLK_IN,
  input wire SERIAL_CHAIN_IN,
  output reg SERIAL_RESULT_OUT,
  output reg SERIAL_RESULT_OE_OUT,
  // sample stream from the analog core, signed-extended raw value
  input wire SAMPLE_VALID_IN,
  output wire SAMPLE_READY_OUT,
  input wire [17:0] SAMPLE_RAW_IN,
  // status
  output reg CONVERTING_OUT,
  output reg CHAIN_MODE_OUT
);
  localparam [17:0] RAW_MAX = {2'b00, `ASRI_CODE_MAX};
  localparam [12:0] CONV_CYC = `ASRI_CONV_CYC;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_CONV = 4'h2;
  localparam [3:0] ST_READ = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // two-flop synchronisers for the host pins
  reg [2:0] strobe_sync_reg;
  reg [2:0] sck_sync_reg;
  reg [1:0] chain_sync_reg;
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      strobe_sync_reg <= 3'h0;
      sck_sync_reg <= 3'h0;
      chain_sync_reg <= 2'h3; // idle high, no false chain mode after reset
    end else begin
      strobe_sync_reg <= {strobe_sync_reg[1:0], CONVERT_STROBE_IN};
      sck_sync_reg <= {sck_sync_reg[1:0], SERIAL_CLK_IN};
      chain_sync_reg <= {chain_sync_reg[0], SERIAL_CHAIN_IN};
    end
  end
  wire strobe_lvl = strobe_sync_reg[1];
  wire chain_lvl = chain_sync_reg[1];
  wire strobe_rise = strobe_sync_reg[1] & ~strobe_sync_reg[2];
  wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];

  // sample stream from the fifo
  wire fifo_valid;
  wire [17:0] fifo_data;
  reg fifo_pop;
  asri_fifo #(
    .WIDTH(18),
    .DEPTH(`ASRI_FIFO_DEPTH),
    .AW(`ASRI_FIFO_AW)
  ) u_fifo (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .wr_valid_in(SAMPLE_VALID_IN),
    .wr_ready_out(SAMPLE_READY_OUT),
    .wr_data_in(SAMPLE_RAW_IN),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_pop),
    .rd_data_out(fifo_data)
  );

  // saturate raw value to straight binary
  reg [15:0] code;
  always @* begin
    if (fifo_data[17]) begin
      code = `ASRI_CODE_MIN;
    end else if (fifo_data > RAW_MAX) begin
      code = `ASRI_CODE_MAX;
    end else begin
      code = fifo_data[15:0];
    end
  end

  // control state
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [12:0] conv_cnt_reg;
  reg [15:0] shift_reg;
  reg [4:0] bit_cnt_reg;
  reg busy_arm_reg;
  reg chain_reg;
  // a strobe edge in the last count cycle restarts instead of finishing
  wire conv_end = (state_reg == ST_CONV) && (conv_cnt_reg == 13'h0) && !strobe_rise;
  wire selected = ~strobe_lvl | ~chain_lvl;

  // next state
  always @* begin
    state_next = state_reg;
    fifo_pop = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (strobe_rise) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          fifo_pop = fifo_valid;
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        if (strobe_rise) begin
          state_next = ST_CONV;
        end else if (bit_cnt_reg == 5'h0 && !chain_reg) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (strobe_rise) begin
          state_next = ST_CONV;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencing registers
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= ST_IDLE;
      conv_cnt_reg <= 13'h0;
      shift_reg <= 16'h0;
      bit_cnt_reg <= 5'h0;
      busy_arm_reg <= 1'b0;
      chain_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (strobe_rise) begin
        chain_reg <= ~chain_lvl;
        conv_cnt_reg <= CONV_CYC - 13'h1;
        busy_arm_reg <= 1'b0;
      end else if (state_reg == ST_CONV) begin
        conv_cnt_reg <= conv_cnt_reg - 13'h1;
      end
      if (conv_end) begin
        shift_reg <= fifo_valid ? code : `ASRI_CODE_MIN;
        bit_cnt_reg <= `ASRI_CHAIN_DELAY;
        busy_arm_reg <= ~chain_reg & selected;
      end else if (state_reg == ST_READ && sck_fall) begin
        if (chain_reg) begin
          // chain data enters at the bottom, emerges 16 clocks later
          shift_reg <= {shift_reg[14:0], chain_lvl};
        end else if (selected && bit_cnt_reg != 5'h0) begin
          shift_reg <= {shift_reg[14:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg - 5'h1;
        end
      end
      if (sck_rise && state_reg == ST_READ && busy_arm_reg) begin
        busy_arm_reg <= 1'b0;
      end
    end
  end

  // output pin drive and enable
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SERIAL_RESULT_OUT <= 1'b0;
      SERIAL_RESULT_OE_OUT <= 1'b0;
      CONVERTING_OUT <= 1'b0;
      CHAIN_MODE_OUT <= 1'b0;
    end else begin
      CONVERTING_OUT <= (state_next == ST_CONV);
      CHAIN_MODE_OUT <= chain_reg;
      if (chain_reg) begin
        // chain output always driven; readout happens with strobe high
        SERIAL_RESULT_OE_OUT <= 1'b1;
        SERIAL_RESULT_OUT <= shift_reg[`ASRI_MSB];
      end else if (!selected || state_reg == ST_DONE || state_reg == ST_IDLE) begin
        SERIAL_RESULT_OE_OUT <= 1'b0;
        SERIAL_RESULT_OUT <= 1'b0;
      end else if (state_reg == ST_CONV) begin
        // selected during conversion: not-ready level
        SERIAL_RESULT_OE_OUT <= 1'b1;
        SERIAL_RESULT_OUT <= 1'b0;
      end else begin
        SERIAL_RESULT_OE_OUT <= 1'b1;
        if (busy_arm_reg) begin
          SERIAL_RESULT_OUT <= 1'b1;
        end else begin
          SERIAL_RESULT_OUT <= shift_reg[`ASRI_MSB];
        end
      end
    end
  end
endmodule // asri_top

// ===== hdl/asri_map.vh
// asri_map.vh - constants for the converter serial readout block
// assumes inclusion by bare name from the top design file only; the fifo does not include it
`ifndef ASRI_MAP_VH
`define ASRI_MAP_VH
`define ASRI_RES_BITS 16
`define ASRI_MSB 15
`define ASRI_CHAIN_DELAY 5'h10
`define ASRI_CODE_MAX 16'hffff
`define ASRI_CODE_MIN 16'h0000
`define ASRI_CLK_MHZ 250
`define ASRI_TCONV_MIN_NS 700
`define ASRI_TCONV_MAX_NS 3200
// conversion count: minimum conversion time of 700 ns at 250 MHz
`define ASRI_CONV_CYC 13'h0af
`define ASRI_FIFO_DEPTH 32
`define ASRI_FIFO_AW 5
`endif

// ===== hdl/asri_fifo.v
// asri_fifo.v - synchronous fifo holding converter samples
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module asri_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // write side
  input wire wr_valid_in,
  output wire wr_ready_out,
  input wire [WIDTH-1:0] wr_data_in,
  // read side
  output wire rd_valid_out,
  input wire rd_ready_in,
  output reg [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire do_wr;
  wire do_rd;
  // honest full and empty from the occupancy count
  assign wr_ready_out = (count_reg != DEPTH);
  assign rd_valid_out = (count_reg != 0);
  assign do_wr = wr_valid_in & wr_ready_out;
  assign do_rd = rd_valid_out & rd_ready_in;
  // storage array, no reset needed
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= wr_data_in;
    end
  end
  // head data registered, updated on read or first write
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= {WIDTH{1'b0}};
    end else if (count_reg == 0 && do_wr) begin
      rd_data_out <= wr_data_in;
    end else if (do_rd) begin
      if (count_reg == 1) begin
        rd_data_out <= wr_data_in;
      end else begin
        rd_data_out <= mem[rd_ptr_reg + 1'b1];
      end
    end
  end
  // pointers and count
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // asri_fifo

// ===== verif/asri_top_properties.sv
// asri_top_properties.sv - port assertions for the readout block
// assumes a bind onto asri_top, one 250 MHz clock domain
`timescale 1ns/1ps
module asri_top_properties (
  // link pins
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire CONVERT_STROBE_IN,
  input wire SERIAL_CLK_IN,
  input wire SERIAL_CHAIN_IN,
  // outputs watched
  input wire SERIAL_RESULT_OUT,
  input wire SERIAL_RESULT_OE_OUT,
  input wire CONVERTING_OUT,
  input wire CHAIN_MODE_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // start and mode capture
  property p_start;
    $rose(CONVERT_STROBE_IN) |-> ##[1:4] CONVERTING_OUT;
  endproperty
  a_start: assert property (p_start) else $error("no conversion start");
  property p_chain;
    $rose(CONVERT_STROBE_IN) && !SERIAL_CHAIN_IN |-> ##[2:5] CHAIN_MODE_OUT;
  endproperty
  a_chain: assert property (p_chain) else $error("chain mode missed");
  property p_sel;
    $rose(CONVERT_STROBE_IN) && SERIAL_CHAIN_IN |-> ##[2:5] !CHAIN_MODE_OUT;
  endproperty
  a_sel: assert property (p_sel) else $error("select mode missed");
  // output enable in both modes
  property p_float;
    (!CHAIN_MODE_OUT && CONVERT_STROBE_IN && SERIAL_CHAIN_IN) [*5] |-> !SERIAL_RESULT_OE_OUT;
  endproperty
  a_float: assert property (p_float) else $error("output not released");
  property p_oe_en;
    $fell(CONVERT_STROBE_IN) && !CHAIN_MODE_OUT && CONVERTING_OUT |-> ##[1:5] SERIAL_RESULT_OE_OUT;
  endproperty
  a_oe_en: assert property (p_oe_en) else $error("output not enabled");
  property p_chain_oe;
    CHAIN_MODE_OUT [*4] |-> SERIAL_RESULT_OE_OUT;
  endproperty
  a_chain_oe: assert property (p_chain_oe) else $error("chain output off");
  // busy level around conversion end
  property p_conv_low;
    CONVERTING_OUT && $past(CONVERTING_OUT) && !CHAIN_MODE_OUT && SERIAL_RESULT_OE_OUT
      |-> !SERIAL_RESULT_OUT;
  endproperty
  a_conv_low: assert property (p_conv_low) else $error("not low in conversion");
  property p_busy;
    $fell(CONVERTING_OUT) && !CHAIN_MODE_OUT && !CONVERT_STROBE_IN && !SERIAL_CLK_IN
      |-> ##[1:3] (SERIAL_RESULT_OUT && SERIAL_RESULT_OE_OUT) [*4];
  endproperty
  a_busy: assert property (p_busy) else $error("ready level missing");
  c_chain: cover property ($rose(CHAIN_MODE_OUT));
  c_oe: cover property ($fell(SERIAL_RESULT_OE_OUT));
  c_busy: cover property (CONVERTING_OUT && SERIAL_RESULT_OE_OUT);
endmodule // asri_top_properties
bind asri_top asri_top_properties i_asri_top_properties (.REF_CLK_IN(REF_CLK_IN),
  .RST_N_IN(RST_N_IN), .CONVERT_STROBE_IN(CONVERT_STROBE_IN), .SERIAL_CLK_IN(SERIAL_CLK_IN),
  .SERIAL_CHAIN_IN(SERIAL_CHAIN_IN), .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT),
  .SERIAL_RESULT_OE_OUT(SERIAL_RESULT_OE_OUT), .CONVERTING_OUT(CONVERTING_OUT),
  .CHAIN_MODE_OUT(CHAIN_MODE_OUT));

// ===== verif/asri_host.sv
// asri_host.sv - host model driving strobe, serial clock and chain input
// assumes the bench calls frame; serial clock stands low between frames
`timescale 1ns/1ps
module asri_host (
  // clock and data in
  input wire clk_in,
  input wire result_in,
  // link pins
  output reg strobe_out,
  output reg sck_out,
  output reg chain_out
);
  // idle levels
  initial begin
    strobe_out = 1'b0;
    sck_out = 1'b0;
    chain_out = 1'b1;
  end
  // one conversion and readout: mode 0 select, 1 chain, 2 select with busy
  task frame(input integer mode, input [15:0] feed, output [31:0] data, output lvl);
    integer i;
    begin
      data = 32'h0;
      @(negedge clk_in);
      strobe_out = 1'b0;
      chain_out = (mode != 1);
      repeat (4) @(negedge clk_in);
      strobe_out = 1'b1;
      repeat (4) @(negedge clk_in);
      if (mode == 2) strobe_out = 1'b0;
      repeat (196) @(negedge clk_in);
      lvl = result_in;
      if (mode == 0) strobe_out = 1'b0;
      repeat (4) @(negedge clk_in);
      // data taken at the rise, chain bit set well before the fall; 64 ns period
      for (i = 0; i < ((mode == 1) ? 32 : 16); i = i + 1) begin
        sck_out = 1'b1;
        data = {data[30:0], result_in};
        if (mode == 1) chain_out = feed[15 - i % 16];
        repeat (8) @(negedge clk_in);
        sck_out = 1'b0;
        repeat (8) @(negedge clk_in);
      end
      strobe_out = (mode == 1);
      chain_out = 1'b1;
      repeat (8) @(negedge clk_in);
    end
  endtask
endmodule // asri_host

// ===== verif/asri_top_tb_top.sv
// asri_top_tb_top.sv - self-checking bench for the readout block
// assumes asri_host on the link pins; the bench feeds the sample fifo
`timescale 1ns/1ps
module asri_top_tb_top;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg sample_valid = 1'b0;
  reg [17:0] sample_raw = 18'h00000;
  wire strobe, sck, chain, result, result_oe, result_line;
  wire sample_ready, converting, chain_mode;
  // a released result line reads as the inverse of the design's bit
  assign result_line = result_oe ? result : ~result;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer i, n, mode;
  reg [15:0] exp_q[$];
  reg [15:0] feed, code;
  reg [31:0] data, rnd;
  reg lvl;
  asri_top i_asri_top (.REF_CLK_IN(ref_clk), .RST_N_IN(rst_n), .CONVERT_STROBE_IN(strobe),
    .SERIAL_CLK_IN(sck), .SERIAL_CHAIN_IN(chain), .SERIAL_RESULT_OUT(result),
    .SERIAL_RESULT_OE_OUT(result_oe), .SAMPLE_VALID_IN(sample_valid),
    .SAMPLE_READY_OUT(sample_ready), .SAMPLE_RAW_IN(sample_raw),
    .CONVERTING_OUT(converting), .CHAIN_MODE_OUT(chain_mode));
  asri_host i_asri_host (.clk_in(ref_clk), .result_in(result_line), .strobe_out(strobe),
    .sck_out(sck), .chain_out(chain));
  // 250 MHz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // saturating code of a raw sample
  function [15:0] sat(input [17:0] raw);
    sat = raw[17] ? 16'h0000 : (raw[16] ? 16'hffff : raw[15:0]);
  endfunction
  // one comparison
  task chk(input [47:0] what, input [31:0] expv, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== expv) begin
        n_fail = n_fail + 1;
        $display("unexpected %0s expected %h seen %h", what, expv, got);
      end
    end
  endtask
  // verdict
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // hang guard
  initial begin
    #400000;
    n_fail = n_fail + 1;
    summarize;
  end
  // fill the fifo until it refuses, then drain it by conversions
  initial begin
    n = $urandom(40);
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    n = 0;
    for (i = 0; i < 40 && n == i; i = i + 1) begin
      @(negedge ref_clk);
      rnd = $urandom;
      case (rnd[1:0])
        2'h0: sample_raw = 18'h3ffff;
        2'h1: sample_raw = 18'h10000;
        default: sample_raw = rnd[19:2];
      endcase
      sample_valid = 1'b1;
      if (sample_ready === 1'b1) begin
        exp_q.push_back(sat(sample_raw));
        n = n + 1;
      end
    end
    @(negedge ref_clk);
    sample_valid = 1'b0;
    chk("fill", 32, n);
    $display("test fill done");
    for (i = 0; i < 33; i = i + 1) begin
      mode = (i == 32) ? 0 : i % 3;
      rnd = $urandom;
      feed = rnd[15:0];
      code = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
      i_asri_host.frame(mode, feed, data, lvl);
      if (mode == 2) chk("busy", 1, lvl);
      else if (mode == 1) chk("chain", {code, feed}, data);
      else chk("select", code, data[15:0]);
      chk("mode", mode == 1, chain_mode);
      chk("oe", mode == 1, result_oe);
      chk("conv", 0, converting);
    end
    $display("test drain done");
    summarize;
  end
endmodule // asri_top_tb_top
